// ---- status_bank_pkg.sv ----
// Constants and types for the bus, wake and input status register bank
// What this block does
// - Prior-state code at bits 7:6: 00 cleared, 01 failure, 10 sleep, 11 reserved.
// - Illegal stop-to-sleep records code 01; sleep without wake source cannot, as any_wake_enabled is tied to one.
// - Sleep attempt with uncleared wake flags records code 10.
// - Watchdog miss count at bits 3:2; 01 after first miss, 10 after second; 11 never.
// - Count self-clears on good trigger or watchdog stop, unless stopped by failure.
// - In configs 2 and 4 the count freezes after the miss that activates the fail output, until a good trigger.
// - Config select zero: first miss only restarts, no fail output, no flag.
// - Serial-fail flag bit 1 sets on invalid command, clears only by host.
// - Failure flag bit 0 sets when fail output activates, held until cleared.
// - Reserved bits always read as zero, clear commands notwithstanding.
// - CAN fault code bits 2:1: 01 thermal, 10 transmit timeout, 11 bus timeout.
// - CAN supply undervoltage sets bit 0 and disables the CAN transmitter.
// - Supply undervoltage monitored only while the CAN mode bit is one.
// - Wake register A: CAN bit 5, timer bit 4, wake inputs bits 2..0.
// - Waking out of fail-safe also sets the matching wake-source flag.
// - Wake register B: second general pin bit 5, first pin bit 4.
// - Level register bit 7 shows development strap level, read only.
// - Level register bit 6 shows interrupt-pin pull-up strap, read only.
// - Level bits 5,4 general pins, bits 2..0 wake inputs; bit 3 reserved.
// - General pin levels update in normal and stop unless the pin is off, or always when plain GPIO.
// - In cyclic sense the wake levels load the sample after each sampling.
// - 16-bit frame: 7-bit address, mode bit (0 read, 1 read-and-clear), data.
// - Flags change only by host clear, except the watchdog miss count.
package status_bank_pkg;
    localparam logic [6:0] ADDR_DEVICE_HISTORY = 7'h43;
    localparam logic [6:0] ADDR_BUS_FAULT = 7'h44;
    localparam logic [6:0] ADDR_WAKE_A = 7'h46;
    localparam logic [6:0] ADDR_WAKE_B = 7'h47;
    localparam logic [6:0] ADDR_INPUT_LEVEL = 7'h48;
    localparam int HIST_LSB = 6;
    localparam int MISS_LSB = 2;
    localparam int SERIAL_FAIL_BIT = 1;
    localparam int FAILURE_BIT = 0;
    localparam int CAN_FAULT_LSB = 1;
    localparam int SUPPLY_LOW_BIT = 0;
    localparam int BUS_WAKE_BIT = 5;
    localparam int TIMER_WAKE_BIT = 4;
    localparam int GP2_BIT = 5;
    localparam int GP1_BIT = 4;
    localparam int DEV_STRAP_BIT = 7;
    localparam int PULLUP_STRAP_BIT = 6;
    localparam logic [7:0] HISTORY_MASK = 8'hCF;
    localparam logic [7:0] BUS_FAULT_MASK = 8'h07;
    localparam logic [7:0] WAKE_A_MASK = 8'h37;
    localparam logic [7:0] WAKE_B_MASK = 8'h30;
    localparam logic [7:0] LEVEL_MASK = 8'hF7;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [1:0] HIST_CLEARED = 2'h0;
    localparam logic [1:0] HIST_FAILURE = 2'h1;
    localparam logic [1:0] HIST_SLEEP = 2'h2;
    localparam logic [1:0] MISS_NONE = 2'h0;
    localparam logic [1:0] MISS_ONE = 2'h1;
    localparam logic [1:0] MISS_TWO = 2'h2;
    localparam logic [1:0] CAN_NO_ERROR = 2'h0;
    localparam logic [1:0] CAN_THERMAL = 2'h1;
    localparam logic [1:0] CAN_TX_DOMINANT = 2'h2;
    localparam logic [1:0] CAN_BUS_DOMINANT = 2'h3;
    localparam int FRAME_BITS = 16;
    typedef enum logic [1:0] {CFG_1, CFG_2, CFG_3, CFG_4} config_t;
    typedef enum logic [1:0] {GP_OFF, GP_WAKE, GP_SWITCH, GP_PLAIN} gp_use_t;
endpackage

// ---- status_bus_if.sv ----
// Serial frame command carrier between the shifter and the register bank
`timescale 1ns/1ns
interface status_bus_if;
    logic cmd_valid;
    logic [6:0] cmd_addr;
    logic cmd_clear;
    logic [7:0] rd_data;
    logic frame_start;
    modport shifter(output cmd_valid, output cmd_addr, output cmd_clear, output frame_start,
        input rd_data);
    modport bank(input cmd_valid, input cmd_addr, input cmd_clear, input frame_start,
        output rd_data);
endinterface

// ---- serial_frame_port.sv ----
// Serial shifter that turns 16-bit frames into read or read-and-clear commands
`timescale 1ns/1ns
module serial_frame_port
    import status_bank_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_bad_frame,
    status_bus_if.shifter bus
);
    logic sclk_q;
    logic cs_n_q;
    logic [15:0] shift_q;
    logic [4:0] count_q;
    logic [7:0] out_q;
    logic rise;
    logic fall;
    logic frame_end;

    assign rise = i_sclk && !sclk_q && !i_cs_n;
    assign fall = !i_sclk && sclk_q && !i_cs_n;
    assign frame_end = i_cs_n && !cs_n_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= i_sclk;
            cs_n_q <= i_cs_n;
        end
    end

    // Address byte goes first; the mode bit is bit 7 of the frame, LSB first
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_q <= 16'h0000;
            count_q <= 5'h00;
        end else if (!i_cs_n && cs_n_q) begin
            count_q <= 5'h00;
        end else if (rise) begin
            shift_q <= {i_sdi, shift_q[15:1]};
            count_q <= count_q + 5'h01;
        end
    end

    // Register contents go out during the data byte of the same frame
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            out_q <= 8'h00;
            o_sdo <= 1'b0;
        end else if (count_q == 5'h08 && rise) begin
            out_q <= bus.rd_data;
        end else if (fall && count_q >= 5'h08) begin
            o_sdo <= out_q[0];
            out_q <= {1'b0, out_q[7:1]};
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bus.cmd_valid <= 1'b0;
            bus.cmd_addr <= 7'h00;
            bus.cmd_clear <= 1'b0;
            o_bad_frame <= 1'b0;
            bus.frame_start <= 1'b0;
        end else begin
            bus.frame_start <= count_q == 5'h07 && rise;
            bus.cmd_addr <= (count_q == 5'h07 && rise) ? shift_q[15:9] : bus.cmd_addr;
            bus.cmd_valid <= frame_end && count_q == 5'(FRAME_BITS);
            bus.cmd_clear <= shift_q[7];
            o_bad_frame <= frame_end && count_q != 5'(FRAME_BITS);
        end
    end
endmodule

// ---- status_register_bank.sv ----
// Device history, bus fault, wake source and input level status registers
`timescale 1ns/1ns
module status_register_bank
    import status_bank_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_invalid_cmd,
    input wire logic i_watchdog_miss_count,
    input wire logic i_wd_good_trigger,
    input wire logic i_wd_stopped,
    input wire logic i_stop_by_watchdog_miss_count,
    input wire logic i_config_select,
    input wire status_bank_pkg::config_t i_config,
    input wire logic i_restart_from_failure,
    input wire logic i_wake_from_fail_safe,
    input wire logic i_illegal_stop_to_sleep,
    input wire logic i_sleep_request,
    input wire logic i_sleep_entered,
    input wire logic i_can_thermal,
    input wire logic i_tx_dominant_timeout,
    input wire logic i_bus_dominant_timeout,
    input wire logic i_can_supply_low,
    input wire logic i_can_mode_bit,
    input wire logic i_bus_wake,
    input wire logic i_timer_wake,
    input wire logic [2:0] i_wake_in,
    input wire logic [2:0] i_wake_in_event,
    input wire logic [1:0] i_gp_pin,
    input wire logic [1:0] i_gp_wake_event,
    input wire status_bank_pkg::gp_use_t i_gp1_use,
    input wire status_bank_pkg::gp_use_t i_gp2_use,
    input wire logic i_normal_or_stop,
    input wire logic i_cyclic_sense,
    input wire logic i_sample_event,
    input wire logic i_test_strap_pin,
    input wire logic i_pullup_strap,
    input wire logic i_strap_capture,
    output logic o_sdo,
    output logic o_fail_output_pin,
    output logic o_can_tx_enable,
    output logic o_restart
);
    import status_bank_pkg::*;

    status_bus_if bus ();

    logic [1:0] prior_state_code_q;
    logic [1:0] watchdog_miss_count_q;
    logic miss_frozen_q;
    logic serial_fail_q;
    logic failure_q;
    logic [1:0] can_fault_q;
    logic bus_supply_low_flag_q;
    logic bus_wake_flag_q;
    logic timer_wake_flag_q;
    logic [2:0] wake_in_flag_q;
    logic [1:0] gp_wake_flag_q;
    logic development_strap_level_q;
    logic pullup_strap_level_q;
    logic [1:0] gp_level_q;
    logic [2:0] wake_in_level_q;
    logic [7:0] rd_mux;
    logic bad_frame;
    logic [7:0] history_view;
    logic [7:0] bus_view;
    logic [7:0] wake_a_view;
    logic [7:0] wake_b_view;
    logic [7:0] level_view;
    logic any_wake_flag;
    logic any_wake_enabled;
    logic fail_event;
    logic [1:0] miss_next;

    serial_frame_port u_port (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cs_n(i_cs_n),
        .i_sclk(i_sclk),
        .i_sdi(i_sdi),
        .o_sdo(o_sdo),
        .o_bad_frame(bad_frame),
        .bus(bus.shifter)
    );

    // A clear applies to the addressed register once the frame ends
    function automatic logic clear_hit(input logic [6:0] addr);
        return bus.cmd_valid && bus.cmd_clear && bus.cmd_addr == addr;
    endfunction

    // Set has priority over a coinciding clear
    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction

    assign any_wake_flag = bus_wake_flag_q | timer_wake_flag_q | (|wake_in_flag_q)
        | (|gp_wake_flag_q);
    assign any_wake_enabled = 1'b1;

    // Views keep reserved bits at zero
    assign history_view = {prior_state_code_q, 2'b00, watchdog_miss_count_q, serial_fail_q,
        failure_q} & HISTORY_MASK;
    assign bus_view = {5'b00000, can_fault_q, bus_supply_low_flag_q} & BUS_FAULT_MASK;
    assign wake_a_view = {2'b00, bus_wake_flag_q, timer_wake_flag_q, 1'b0,
        wake_in_flag_q} & WAKE_A_MASK;
    assign wake_b_view = {2'b00, gp_wake_flag_q, 4'h0} & WAKE_B_MASK;
    assign level_view = {development_strap_level_q, pullup_strap_level_q, gp_level_q, 1'b0,
        wake_in_level_q} & LEVEL_MASK;

    always_comb begin
        case (bus.cmd_addr)
            ADDR_DEVICE_HISTORY: rd_mux = history_view;
            ADDR_BUS_FAULT: rd_mux = bus_view;
            ADDR_WAKE_A: rd_mux = wake_a_view;
            ADDR_WAKE_B: rd_mux = wake_b_view;
            ADDR_INPUT_LEVEL: rd_mux = level_view;
            default: rd_mux = RESET_VALUE;
        endcase
    end
    // Contents are captured at the first data-byte clock; clearing happens at frame end
    assign bus.rd_data = rd_mux;

    // Miss count: first miss shows 01 in every config, a further miss shows 10 unless the count is frozen
    always_comb begin
        miss_next = watchdog_miss_count_q;
        if (i_watchdog_miss_count && !miss_frozen_q) begin
            if (watchdog_miss_count_q == MISS_NONE) begin
                miss_next = MISS_ONE;
            end else begin
                miss_next = MISS_TWO;
            end
        end
    end

    // Fail output: config 2 on first miss, others on second; select low never on first
    assign fail_event = i_watchdog_miss_count && !miss_frozen_q && ((i_config == CFG_2 && i_config_select)
        || watchdog_miss_count_q != MISS_NONE);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            watchdog_miss_count_q <= MISS_NONE;
            miss_frozen_q <= 1'b0;
        end else if (i_wd_good_trigger) begin
            watchdog_miss_count_q <= MISS_NONE;
            miss_frozen_q <= 1'b0;
        end else if (i_wd_stopped && !i_stop_by_watchdog_miss_count) begin
            watchdog_miss_count_q <= MISS_NONE;
        end else begin
            watchdog_miss_count_q <= miss_next;
            if (fail_event && (i_config == CFG_2 || i_config == CFG_4)) begin
                miss_frozen_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_fail_output_pin <= 1'b0;
            o_restart <= 1'b0;
        end else begin
            if (fail_event) begin
                o_fail_output_pin <= 1'b1;
            end
            o_restart <= i_watchdog_miss_count;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prior_state_code_q <= HIST_CLEARED;
        end else if (i_restart_from_failure || i_wake_from_fail_safe || i_illegal_stop_to_sleep
            || (i_sleep_request && !any_wake_enabled)) begin
            prior_state_code_q <= HIST_FAILURE;
        end else if (i_sleep_entered || (i_sleep_request && any_wake_flag)) begin
            prior_state_code_q <= HIST_SLEEP;
        end else if (clear_hit(ADDR_DEVICE_HISTORY)) begin
            prior_state_code_q <= HIST_CLEARED;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            serial_fail_q <= 1'b0;
            failure_q <= 1'b0;
        end else begin
            serial_fail_q <= flag_next(serial_fail_q, i_invalid_cmd | bad_frame,
                clear_hit(ADDR_DEVICE_HISTORY));
            failure_q <= flag_next(failure_q, fail_event,
                clear_hit(ADDR_DEVICE_HISTORY));
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            can_fault_q <= CAN_NO_ERROR;
        end else if (i_bus_dominant_timeout) begin
            can_fault_q <= CAN_BUS_DOMINANT;
        end else if (i_tx_dominant_timeout) begin
            can_fault_q <= CAN_TX_DOMINANT;
        end else if (i_can_thermal) begin
            can_fault_q <= CAN_THERMAL;
        end else if (clear_hit(ADDR_BUS_FAULT)) begin
            can_fault_q <= CAN_NO_ERROR;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_supply_low_flag_q <= 1'b0;
            o_can_tx_enable <= 1'b0;
        end else begin
            bus_supply_low_flag_q <= flag_next(bus_supply_low_flag_q,
                i_can_supply_low && i_can_mode_bit, clear_hit(ADDR_BUS_FAULT));
            o_can_tx_enable <= i_can_mode_bit && !(i_can_supply_low && i_can_mode_bit);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_wake_flag_q <= 1'b0;
            timer_wake_flag_q <= 1'b0;
            wake_in_flag_q <= 3'b000;
            gp_wake_flag_q <= 2'b00;
        end else begin
            // Wake events from fail-safe arrive on the same event inputs
            bus_wake_flag_q <= flag_next(bus_wake_flag_q, i_bus_wake,
                clear_hit(ADDR_WAKE_A));
            timer_wake_flag_q <= flag_next(timer_wake_flag_q, i_timer_wake,
                clear_hit(ADDR_WAKE_A));
            wake_in_flag_q <= i_wake_in_event
                | (wake_in_flag_q & {3{!clear_hit(ADDR_WAKE_A)}});
            gp_wake_flag_q <= i_gp_wake_event
                | (gp_wake_flag_q & {2{!clear_hit(ADDR_WAKE_B)}});
        end
    end

    // Straps are caught after reset release, then held
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            development_strap_level_q <= 1'b0;
            pullup_strap_level_q <= 1'b0;
        end else if (i_strap_capture) begin
            development_strap_level_q <= i_test_strap_pin;
            pullup_strap_level_q <= i_pullup_strap;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gp_level_q <= 2'b00;
        end else begin
            if (i_gp1_use == GP_PLAIN || (i_normal_or_stop && i_gp1_use != GP_OFF)) begin
                gp_level_q[0] <= i_gp_pin[0];
            end
            if (i_gp2_use == GP_PLAIN || (i_normal_or_stop && i_gp2_use != GP_OFF)) begin
                gp_level_q[1] <= i_gp_pin[1];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_in_level_q <= 3'b000;
        end else if (!i_cyclic_sense || i_sample_event) begin
            wake_in_level_q <= i_wake_in;
        end
    end
endmodule

// ---- status_bank_checker.sv ----
// Port-level checks for the status register bank
`timescale 1ns/1ns
module status_bank_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_watchdog_miss_count,
    input wire logic i_can_supply_low,
    input wire logic i_can_mode_bit,
    input wire logic o_sdo,
    input wire logic o_fail_output_pin,
    input wire logic o_can_tx_enable,
    input wire logic o_restart
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_restart_on_miss: assert property (i_watchdog_miss_count |-> ##[1:2] o_restart)
        else $error("restart missing after watchdog miss");
    a_restart_has_cause: assert property (
        o_restart |-> $past(i_watchdog_miss_count) || $past(i_watchdog_miss_count, 2))
        else $error("restart without watchdog miss");
    a_fail_pin_sticky: assert property (o_fail_output_pin |=> o_fail_output_pin)
        else $error("fail output dropped");
    a_fail_pin_cause: assert property (
        $rose(o_fail_output_pin) |-> $past(i_watchdog_miss_count) || $past(i_watchdog_miss_count, 2)
            || $past(i_watchdog_miss_count, 3))
        else $error("fail output without watchdog miss");
    a_tx_off_on_low: assert property (
        i_can_supply_low && i_can_mode_bit |-> ##[1:3] !o_can_tx_enable)
        else $error("transmitter still enabled on supply low");
    a_clean_after_reset: assert property (
        $fell(i_rst) |-> !o_restart && !o_fail_output_pin && !o_sdo)
        else $error("outputs not clear after reset");
    a_sdo_idle_hold: assert property (i_cs_n [*8] |=> $stable(o_sdo))
        else $error("serial output moved while deselected");
    a_sdo_high_hold: assert property (i_sclk [*4] |-> $stable(o_sdo))
        else $error("serial output moved while clock high");
endmodule

bind status_register_bank status_bank_checker chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_watchdog_miss_count(i_watchdog_miss_count),
    .i_can_supply_low(i_can_supply_low), .i_can_mode_bit(i_can_mode_bit), .o_sdo(o_sdo),
    .o_fail_output_pin(o_fail_output_pin), .o_can_tx_enable(o_can_tx_enable),
    .o_restart(o_restart));

// ---- host_model.sv ----
// Host controller model issuing serial frames LSB first
`timescale 1ns/1ns
module host_model (
    input wire logic i_clk,
    input wire logic i_sdo,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_sdi
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end
    task automatic hold();
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    // Short frames provoke a refusal
    task automatic frame(input logic [6:0] a, input logic c, input int nbits,
        output logic [7:0] rd);
        logic [15:0] word;
        word = {8'h00, c, a};
        rd = 8'h00;
        o_cs_n = 1'b0;
        hold();
        for (int i = 0; i < nbits; i++) begin
            o_sdi = word[i];
            hold();
            o_sclk = 1'b1;
            hold();
            o_sclk = 1'b0;
            if (i >= 8) begin
                hold();
                rd[i - 8] = i_sdo;
            end
        end
        hold();
        o_cs_n = 1'b1;
        // Released data line falls to its pull-down level
        o_sdi = 1'b0;
        hold();
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the status register bank
`timescale 1ns/1ns
module tb_top;
    import status_bank_pkg::*;
    logic i_clk, i_rst, i_cs_n, i_sclk, i_sdi, o_sdo, o_fail_output_pin, o_can_tx_enable;
    logic o_restart, i_invalid_cmd, i_watchdog_miss_count, i_wd_good_trigger, i_wd_stopped;
    logic i_stop_by_watchdog_miss_count, i_config_select, i_restart_from_failure, i_wake_from_fail_safe;
    logic i_illegal_stop_to_sleep, i_sleep_request, i_sleep_entered, i_can_thermal;
    logic i_tx_dominant_timeout, i_bus_dominant_timeout, i_can_supply_low, i_can_mode_bit;
    logic i_bus_wake, i_timer_wake, i_normal_or_stop, i_cyclic_sense, i_sample_event;
    logic i_test_strap_pin, i_pullup_strap, i_strap_capture;
    logic [2:0] i_wake_in, i_wake_in_event;
    logic [1:0] i_gp_pin, i_gp_wake_event;
    config_t i_config;
    gp_use_t i_gp1_use, i_gp2_use;
    int errors = 0, samples_checked = 0, cycles = 0;

    host_model host (.i_clk(i_clk), .i_sdo(o_sdo), .o_cs_n(i_cs_n), .o_sclk(i_sclk),
        .o_sdi(i_sdi));
    status_register_bank DUT (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
        .i_sclk(i_sclk), .i_sdi(i_sdi), .i_invalid_cmd(i_invalid_cmd), .i_watchdog_miss_count(i_watchdog_miss_count),
        .i_wd_good_trigger(i_wd_good_trigger), .i_wd_stopped(i_wd_stopped),
        .i_stop_by_watchdog_miss_count(i_stop_by_watchdog_miss_count), .i_config_select(i_config_select),
        .i_config(i_config), .i_restart_from_failure(i_restart_from_failure),
        .i_wake_from_fail_safe(i_wake_from_fail_safe), .i_sleep_entered(i_sleep_entered),
        .i_illegal_stop_to_sleep(i_illegal_stop_to_sleep), .i_sleep_request(i_sleep_request),
        .i_can_thermal(i_can_thermal), .i_tx_dominant_timeout(i_tx_dominant_timeout),
        .i_bus_dominant_timeout(i_bus_dominant_timeout), .i_can_supply_low(i_can_supply_low),
        .i_can_mode_bit(i_can_mode_bit), .i_bus_wake(i_bus_wake), .i_timer_wake(i_timer_wake),
        .i_wake_in(i_wake_in), .i_wake_in_event(i_wake_in_event), .i_gp_pin(i_gp_pin),
        .i_gp_wake_event(i_gp_wake_event), .i_gp1_use(i_gp1_use), .i_gp2_use(i_gp2_use),
        .i_normal_or_stop(i_normal_or_stop), .i_cyclic_sense(i_cyclic_sense),
        .i_sample_event(i_sample_event), .i_test_strap_pin(i_test_strap_pin),
        .i_pullup_strap(i_pullup_strap), .i_strap_capture(i_strap_capture), .o_sdo(o_sdo),
        .o_fail_output_pin(o_fail_output_pin), .o_can_tx_enable(o_can_tx_enable),
        .o_restart(o_restart));

    task automatic tk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tk(1);
        s = 1'b0;
        tk(3);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [6:0] a, input logic c, input logic [7:0] e);
        logic [7:0] v;
        host.frame(a, c, 16, v);
        tk(4);
        chk(n, e, v);
    endtask
    task automatic do_reset();
        i_rst = 1'b1;
        tk(5);
        i_rst = 1'b0;
        tk(2);
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic t_watchdog();
        i_config = CFG_1;
        i_config_select = 1'b0;
        pulse(i_watchdog_miss_count);
        chk("fail pin first", 8'h00, {7'h00, o_fail_output_pin});
        rchk("one miss", ADDR_DEVICE_HISTORY, 1'b0, 8'h04);
        pulse(i_watchdog_miss_count);
        chk("fail pin second", 8'h01, {7'h00, o_fail_output_pin});
        rchk("two misses", ADDR_DEVICE_HISTORY, 1'b1, 8'h09);
        rchk("count kept", ADDR_DEVICE_HISTORY, 1'b0, 8'h08);
        i_wd_stopped = 1'b1;
        tk(4);
        i_wd_stopped = 1'b0;
        rchk("count stop", ADDR_DEVICE_HISTORY, 1'b0, 8'h00);
        do_reset();
        i_config = CFG_2;
        i_config_select = 1'b1;
        pulse(i_watchdog_miss_count);
        pulse(i_watchdog_miss_count);
        rchk("frozen count", ADDR_DEVICE_HISTORY, 1'b1, 8'h05);
        pulse(i_wd_good_trigger);
        rchk("count good", ADDR_DEVICE_HISTORY, 1'b0, 8'h00);
        $display("test watchdog done");
    endtask
    task automatic t_history();
        logic [7:0] v;
        do_reset();
        pulse(i_illegal_stop_to_sleep);
        rchk("illegal sleep", ADDR_DEVICE_HISTORY, 1'b1, 8'h40);
        rchk("history clear", ADDR_DEVICE_HISTORY, 1'b0, 8'h00);
        pulse(i_bus_wake);
        pulse(i_sleep_request);
        rchk("sleep flags set", ADDR_DEVICE_HISTORY, 1'b1, 8'h80);
        pulse(i_wake_from_fail_safe);
        rchk("fail safe wake", ADDR_DEVICE_HISTORY, 1'b1, 8'h40);
        pulse(i_restart_from_failure);
        rchk("failure restart", ADDR_DEVICE_HISTORY, 1'b1, 8'h40);
        host.frame(ADDR_DEVICE_HISTORY, 1'b1, 8, v);
        rchk("short frame", ADDR_DEVICE_HISTORY, 1'b1, 8'h02);
        pulse(i_invalid_cmd);
        rchk("invalid cmd", ADDR_DEVICE_HISTORY, 1'b1, 8'h02);
        rchk("reserved zero", ADDR_DEVICE_HISTORY, 1'b0, 8'h00);
        rchk("unmapped", 7'h45, 1'b0, 8'h00);
        $display("test history done");
    endtask
    task automatic t_wake();
        logic [7:0] ea [2] = '{8'h21, 8'h16};
        logic [7:0] eb [2] = '{8'h10, 8'h20};
        do_reset();
        for (int k = 0; k < 2; k++) begin
            i_bus_wake = (k == 0);
            i_timer_wake = (k == 1);
            i_wake_in_event = (k == 0) ? 3'h1 : 3'h6;
            i_gp_wake_event = (k == 0) ? 2'h1 : 2'h2;
            tk(1);
            {i_bus_wake, i_timer_wake, i_wake_in_event, i_gp_wake_event} = '0;
            tk(3);
            rchk("wake a", ADDR_WAKE_A, 1'b1, ea[k]);
            rchk("wake a clear", ADDR_WAKE_A, 1'b0, 8'h00);
            rchk("wake b", ADDR_WAKE_B, 1'b1, eb[k]);
            rchk("wake b clear", ADDR_WAKE_B, 1'b0, 8'h00);
        end
        $display("test wake done");
    endtask
    task automatic t_bus();
        do_reset();
        i_can_mode_bit = 1'b1;
        for (int k = 1; k < 4; k++) begin
            i_can_thermal = (k == 1);
            i_tx_dominant_timeout = (k == 2);
            i_bus_dominant_timeout = (k == 3);
            tk(1);
            {i_can_thermal, i_tx_dominant_timeout, i_bus_dominant_timeout} = '0;
            tk(3);
            rchk("can code", ADDR_BUS_FAULT, 1'b1, {5'h00, k[1:0], 1'b0});
        end
        i_can_mode_bit = 1'b0;
        pulse(i_can_supply_low);
        rchk("supply ignored", ADDR_BUS_FAULT, 1'b0, 8'h00);
        i_can_mode_bit = 1'b1;
        i_can_supply_low = 1'b1;
        tk(1);
        chk("tx enable", 8'h00, {7'h00, o_can_tx_enable});
        i_can_supply_low = 1'b0;
        rchk("supply low", ADDR_BUS_FAULT, 1'b1, 8'h01);
        $display("test bus done");
    endtask
    task automatic t_levels();
        do_reset();
        i_test_strap_pin = 1'b1;
        i_wake_in = 3'h5;
        i_gp_pin = 2'h2;
        i_normal_or_stop = 1'b1;
        pulse(i_strap_capture);
        rchk("levels", ADDR_INPUT_LEVEL, 1'b0, 8'hA5);
        i_normal_or_stop = 1'b0;
        i_cyclic_sense = 1'b1;
        i_wake_in = 3'h2;
        i_gp_pin = 2'h1;
        tk(4);
        rchk("no sample yet", ADDR_INPUT_LEVEL, 1'b1, 8'h95);
        pulse(i_sample_event);
        rchk("sampled", ADDR_INPUT_LEVEL, 1'b0, 8'h92);
        i_gp1_use = GP_WAKE;
        i_gp_pin = 2'h0;
        tk(4);
        rchk("gp held", ADDR_INPUT_LEVEL, 1'b0, 8'h92);
        i_normal_or_stop = 1'b1;
        tk(4);
        rchk("gp updated", ADDR_INPUT_LEVEL, 1'b0, 8'h82);
        $display("test levels done");
    endtask

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        i_rst = 1'b1;
        {i_invalid_cmd, i_watchdog_miss_count, i_wd_good_trigger, i_wd_stopped, i_stop_by_watchdog_miss_count,
            i_config_select, i_restart_from_failure, i_wake_from_fail_safe,
            i_illegal_stop_to_sleep, i_sleep_request, i_sleep_entered, i_can_thermal,
            i_tx_dominant_timeout, i_bus_dominant_timeout, i_can_supply_low, i_can_mode_bit,
            i_bus_wake, i_timer_wake, i_normal_or_stop, i_cyclic_sense, i_sample_event,
            i_test_strap_pin, i_pullup_strap, i_strap_capture, i_wake_in, i_wake_in_event,
            i_gp_pin, i_gp_wake_event} = '0;
        i_config = CFG_1;
        i_gp1_use = GP_PLAIN;
        i_gp2_use = GP_PLAIN;
        tk(5);
        i_rst = 1'b0;
        tk(2);
        rchk("history reset", ADDR_DEVICE_HISTORY, 1'b0, RESET_VALUE);
        rchk("bus reset", ADDR_BUS_FAULT, 1'b0, RESET_VALUE);
        t_watchdog();
        t_history();
        t_wake();
        t_bus();
        t_levels();
        conclude();
    end
endmodule
